/* File: verilog/gpp_ports.v */
// General purpose ports two, three and four with register access.
//
// What this block does
// - Direction one floats pin, zero drives latch.
// - Three eight-bit ports, per-bit direction.
// - Port two bit zero is external interrupt.
// - Port two bits seven to four detect change.
// - Software controlled weak pull-up on port two.
// - Pull-up enable low bit7, edge bit6.
// - Directions and option reset to all ones, except port five direction, which resets to 8'h07.
// - Data latches not reset.
// - Enabled peripheral overrides port three direction.
// - Port three bits zero to two share timer/capture.
// - Port three bits three to five serial.
// - Slave mode hands port four to slave port.
// - Port two bits six, seven serial programming.
// - Read returns pins (port four latch in slave mode), write updates latch, except port four while the slave port drives.
// - Input mismatch against value captured at last read or write sets flag.
// - Pull-up off for outputs and at reset.
// - Access ends mismatch; persisting mismatch sets flag.
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_ports (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output reg  [7:0] rdata,
   input  wire [7:0] two_pin_in,
   output wire [7:0] two_pin_out,
   output wire [7:0] two_pin_oe_n,
   output wire [7:0] two_pullup_on,
   input  wire [7:0] three_pin_in,
   output wire [7:0] three_pin_out,
   output wire [7:0] three_pin_oe_n,
   input  wire [7:0] three_ovr_en,
   input  wire [7:0] three_ovr_dir,
   input  wire [7:0] three_ovr_dat,
   output wire [7:0] three_periph_in,
   input  wire [7:0] four_pin_in,
   output wire [7:0] four_pin_out,
   output wire [7:0] four_pin_oe_n,
   input  wire [7:0] slave_port_data,
   input  wire       slave_port_drive,
   output wire [7:0] slave_port_pins,
   output wire       slave_port_mode,
   input  wire       serial_prog_mode,
   output wire       serial_prog_clk,
   output wire       serial_prog_dat,
   output wire       ext_irq_pin,
   output wire       ext_irq_edge_sel,
   output reg        ext_irq_event,
   output wire       change_irq_flag
);
   reg  [7:0] port_two_data_r;
   reg  [7:0] port_three_data_r;
   reg  [7:0] port_four_data_r;
   reg  [7:0] option_config_r;
   reg  [7:0] port_two_direction_r;
   reg  [7:0] port_three_direction_r;
   reg  [7:0] port_four_direction_r;
   reg  [7:0] port_five_direction_r;
   reg  [7:0] two_last_read_r;
   reg        change_flag_r;
   reg        ext_flag_r;
   reg        int_prev_r;
   reg  [7:0] rdata_nxt;
   wire [7:0] two_sync;
   wire [7:0] three_sync;
   wire [7:0] four_sync;
   wire [7:0] three_eff_dir;
   wire [7:0] four_dir_eff;
   wire [7:0] change_vec;
   wire       mismatch;
   wire       two_access;
   wire       int_edge;

   function [7:0] mask_inputs;
      input [7:0] dir;
      input [7:0] mask;
      begin
         mask_inputs = dir & mask;
      end
   endfunction

   gpp_sync u_sync_two (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d_in  (two_pin_in),
      .q_out (two_sync)
   );

   gpp_sync u_sync_three (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d_in  (three_pin_in),
      .q_out (three_sync)
   );

   gpp_sync u_sync_four (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d_in  (four_pin_in),
      .q_out (four_sync)
   );

   assign two_pin_out   = port_two_data_r;
   assign two_pin_oe_n  = port_two_direction_r;
   assign two_pullup_on = port_two_direction_r &
                          {8{~option_config_r[`GPP_BIT_PULLUP_N]}};

   gpp_pin_mux u_mux_three (
      .latch    (port_three_data_r),
      .dir      (port_three_direction_r),
      .ovr_en   (three_ovr_en),
      .ovr_dir  (three_ovr_dir),
      .ovr_dat  (three_ovr_dat),
      .eff_dir  (three_eff_dir),
      .pin_out  (three_pin_out),
      .pin_oe_n (three_pin_oe_n)
   );
   assign three_periph_in = three_sync;

   assign slave_port_mode = port_five_direction_r[`GPP_BIT_SLAVE_MODE];
   assign four_dir_eff    = slave_port_mode ? {8{~slave_port_drive}}
                                            : port_four_direction_r;
   gpp_pin_mux u_mux_four (
      .latch    (port_four_data_r),
      .dir      (four_dir_eff),
      .ovr_en   (8'h00),
      .ovr_dir  (8'h00),
      .ovr_dat  (8'h00),
      .eff_dir  (),
      .pin_out  (four_pin_out),
      .pin_oe_n (four_pin_oe_n)
   );
   assign slave_port_pins = four_sync;

   assign serial_prog_clk = serial_prog_mode & two_sync[6];
   assign serial_prog_dat = serial_prog_mode & two_sync[7];

   assign ext_irq_pin      = two_sync[0];
   assign ext_irq_edge_sel = option_config_r[`GPP_BIT_EDGE_SEL];
   assign int_edge = ext_irq_edge_sel ? (ext_irq_pin & ~int_prev_r)
                                      : (~ext_irq_pin & int_prev_r);

   // Only inputs among bits seven to four.
   assign change_vec = (two_sync ^ two_last_read_r) &
                       mask_inputs(port_two_direction_r, `GPP_CHANGE_MASK);
   assign mismatch   = |change_vec;
   assign two_access = (rd_stb | wr_stb) && (addr == `GPP_ADDR_TWO_DATA);
   assign change_irq_flag = change_flag_r;

   always @(posedge mclk) begin
      if (wr_stb) begin
         case (addr)
            `GPP_ADDR_TWO_DATA:   port_two_data_r   <= wdata;
            `GPP_ADDR_THREE_DATA: port_three_data_r <= wdata;
            default:              ;
         endcase
      end
      if (slave_port_mode && !slave_port_drive &&
          wr_stb && addr == `GPP_ADDR_FOUR_DATA) begin
         port_four_data_r <= wdata;
      end else if (slave_port_mode && slave_port_drive) begin
         port_four_data_r <= port_four_data_r;
      end else if (wr_stb && addr == `GPP_ADDR_FOUR_DATA) begin
         port_four_data_r <= wdata;
      end
   end

   // Directions and option reset to ones; port five direction resets to 8'h07.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         option_config_r        <= `GPP_RST_OPTION;
         port_two_direction_r   <= `GPP_RST_DIR;
         port_three_direction_r <= `GPP_RST_DIR;
         port_four_direction_r  <= `GPP_RST_DIR;
         port_five_direction_r  <= `GPP_RST_FIVE_DIR;
      end else if (wr_stb) begin
         case (addr)
            `GPP_ADDR_OPTION:    option_config_r        <= wdata;
            `GPP_ADDR_TWO_DIR:   port_two_direction_r   <= wdata;
            `GPP_ADDR_THREE_DIR: port_three_direction_r <= wdata;
            `GPP_ADDR_FOUR_DIR:  port_four_direction_r  <= wdata;
            `GPP_ADDR_FIVE_DIR:  port_five_direction_r  <= wdata;
            default:             ;
         endcase
      end
   end

   // Change and external interrupt flags; a set beats a clear.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         two_last_read_r <= `GPP_ZERO;
         change_flag_r   <= 1'b0;
         ext_flag_r      <= 1'b0;
         int_prev_r      <= 1'b0;
         ext_irq_event   <= 1'b0;
      end else begin
         int_prev_r    <= ext_irq_pin;
         ext_irq_event <= int_edge;
         if (two_access) begin
            two_last_read_r <= two_sync;
         end
         if (mismatch && !two_access) begin
            change_flag_r <= 1'b1;
         end else if (wr_stb && addr == `GPP_ADDR_INTCTL &&
                      !wdata[`GPP_BIT_CHANGE_FLAG]) begin
            change_flag_r <= 1'b0;
         end
         if (int_edge) begin
            ext_flag_r <= 1'b1;
         end else if (wr_stb && addr == `GPP_ADDR_INTCTL &&
                      !wdata[`GPP_BIT_EXT_FLAG]) begin
            ext_flag_r <= 1'b0;
         end
      end
   end

   always @* begin
      case (addr)
         `GPP_ADDR_TWO_DATA:   rdata_nxt = two_sync;
         `GPP_ADDR_THREE_DATA: rdata_nxt = three_sync;
         `GPP_ADDR_FOUR_DATA:  rdata_nxt = slave_port_mode ?
                                           port_four_data_r : four_sync;
         `GPP_ADDR_OPTION:     rdata_nxt = option_config_r;
         `GPP_ADDR_TWO_DIR:    rdata_nxt = port_two_direction_r;
         `GPP_ADDR_THREE_DIR:  rdata_nxt = three_eff_dir;
         `GPP_ADDR_FOUR_DIR:   rdata_nxt = port_four_direction_r;
         `GPP_ADDR_FIVE_DIR:   rdata_nxt = port_five_direction_r;
         `GPP_ADDR_INTCTL:     rdata_nxt = {6'h00, ext_flag_r,
                                            change_flag_r};
         default:              rdata_nxt = `GPP_ZERO;
      endcase
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `GPP_ZERO;
      end else if (rd_stb) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= `GPP_ZERO;
      end
   end
endmodule

/* File: verilog/gpp_defines.vh */
// Register map, field positions and reset values for the port block.
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH
`define GPP_AW              8
`define GPP_DW              8
`define GPP_ADDR_TWO_DATA   8'h06
`define GPP_ADDR_THREE_DATA 8'h07
`define GPP_ADDR_FOUR_DATA  8'h08
`define GPP_ADDR_OPTION     8'h81
`define GPP_ADDR_TWO_DIR    8'h86
`define GPP_ADDR_THREE_DIR  8'h87
`define GPP_ADDR_FOUR_DIR   8'h88
`define GPP_ADDR_FIVE_DIR   8'h89
`define GPP_ADDR_INTCTL     8'h0b
`define GPP_RST_DIR         8'hff
`define GPP_RST_OPTION      8'hff
`define GPP_RST_FIVE_DIR    8'h07
`define GPP_ZERO            8'h00
`define GPP_BIT_PULLUP_N    7
`define GPP_BIT_EDGE_SEL    6
`define GPP_BIT_SLAVE_MODE  4
`define GPP_BIT_CHANGE_FLAG 0
`define GPP_BIT_EXT_FLAG    1
`define GPP_CHANGE_MASK     8'hf0
`endif

/* File: verilog/gpp_sync.v */
// Two-stage synchroniser for an eight-bit group of pin inputs.
`timescale 1ns/1ps
module gpp_sync (
   input  wire       mclk,
   input  wire       rst_b,
   input  wire [7:0] d_in,
   output reg  [7:0] q_out
);
   reg [7:0] meta_r;

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 8'h00;
         q_out  <= 8'h00;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule

/* File: verilog/gpp_pin_mux.v */
// Per-bit pin driver: direction override and output enable.
`timescale 1ns/1ps
module gpp_pin_mux (
   input  wire [7:0] latch,
   input  wire [7:0] dir,
   input  wire [7:0] ovr_en,
   input  wire [7:0] ovr_dir,
   input  wire [7:0] ovr_dat,
   output wire [7:0] eff_dir,
   output wire [7:0] pin_out,
   output wire [7:0] pin_oe_n
);
   assign eff_dir  = (ovr_en & ovr_dir) | (~ovr_en & dir);
   assign pin_out  = (ovr_en & ovr_dat) | (~ovr_en & latch);
   assign pin_oe_n = eff_dir;
endmodule

/* File: sim/gpp_ports_monitor.sv */
// Concurrent checks on the ports of the port block.
`timescale 1ns/1ps
module gpp_ports_monitor (
   input wire       mclk,
   input wire       rst_b,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr_stb,
   input wire       rd_stb,
   input wire [7:0] rdata,
   input wire [7:0] two_pin_in,
   input wire [7:0] two_pin_out,
   input wire [7:0] two_pin_oe_n,
   input wire [7:0] two_pullup_on,
   input wire [7:0] three_pin_out,
   input wire [7:0] three_pin_oe_n,
   input wire [7:0] three_ovr_en,
   input wire [7:0] three_ovr_dir,
   input wire [7:0] three_ovr_dat,
   input wire       slave_port_mode,
   input wire       serial_prog_mode,
   input wire       serial_prog_clk,
   input wire       serial_prog_dat,
   input wire       ext_irq_pin,
   input wire       ext_irq_edge_sel,
   input wire       ext_irq_event,
   input wire       change_irq_flag
);
   reg [1:0] up_r;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         up_r <= 2'h0;
      else if (up_r != 2'h3)
         up_r <= up_r + 2'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   dir_write_a:
      assert property (wr_stb && addr == 8'h86 |=> two_pin_oe_n == $past(wdata))
      else $error("port two direction not applied");
   latch_write_a:
      assert property (wr_stb && addr == 8'h06 |=> two_pin_out == $past(wdata))
      else $error("port two latch not written");
   option_bits_a:
      assert property (wr_stb && addr == 8'h81 |=> ext_irq_edge_sel ==
         $past(wdata[6]) && two_pullup_on == ($past(wdata[7]) ? 8'h00 :
         two_pin_oe_n)) else $error("option bits misplaced");
   pullup_off_a:
      assert property ((two_pullup_on & ~two_pin_oe_n) == 8'h00)
      else $error("pull-up on a driven pin");
   ovr_take_a:
      assert property (((three_pin_oe_n ^ three_ovr_dir) & three_ovr_en) == 8'h00
         && ((three_pin_out ^ three_ovr_dat) & three_ovr_en & ~three_ovr_dir)
         == 8'h00) else $error("peripheral override ignored");
   ext_pin_a:
      assert property (up_r == 2'h3 |-> ext_irq_pin == $past(two_pin_in[0], 2))
      else $error("external interrupt pin wrong");
   pin_read_a:
      assert property (rd_stb && addr == 8'h06 && up_r == 2'h3 |=>
         rdata == $past(two_pin_in, 3)) else $error("port two read wrong");
   unmapped_read_a:
      assert property (rd_stb && addr == 8'h40 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   slave_mode_a:
      assert property (wr_stb && addr == 8'h89 |=>
         slave_port_mode == $past(wdata[4])) else $error("slave mode wrong");
   prog_pins_a:
      assert property (serial_prog_mode && $past(serial_prog_mode) &&
         up_r == 2'h3 |-> serial_prog_clk == $past(two_pin_in[6], 2) &&
         serial_prog_dat == $past(two_pin_in[7], 2))
      else $error("serial programming pins wrong");
   cover property ($rose(change_irq_flag));
   cover property (ext_irq_event);
   cover property ($rose(slave_port_mode));
endmodule
bind gpp_ports gpp_ports_monitor i_gpp_ports_monitor (.mclk, .rst_b, .addr,
   .wdata, .wr_stb, .rd_stb, .rdata, .two_pin_in, .two_pin_out,
   .two_pin_oe_n, .two_pullup_on, .three_pin_out, .three_pin_oe_n,
   .three_ovr_en, .three_ovr_dir, .three_ovr_dat, .slave_port_mode,
   .serial_prog_mode, .serial_prog_clk, .serial_prog_dat, .ext_irq_pin,
   .ext_irq_edge_sel, .ext_irq_event, .change_irq_flag);

/* File: sim/gpp_pin_env.sv */
// External circuitry on the eight pins of one port.
`timescale 1ns/1ps
module gpp_pin_env (
   input  wire [7:0] drv,
   input  wire [7:0] oe_n,
   input  wire [7:0] pull,
   input  wire [7:0] ext,
   input  wire [7:0] ext_on,
   input  wire [7:0] pin_fb,
   output wire [7:0] pin
);
   assign pin = (~oe_n & drv) | (oe_n & ext_on & ext)
              | (oe_n & ~ext_on & pull) | (oe_n & ~ext_on & ~pull & ~pin_fb);
endmodule

/* File: sim/gpp_ports_tb.sv */
// Self-checking bench for the port block.
`timescale 1ns/1ps
module gpp_ports_tb;
   reg        mclk, rst_b, wr_stb, rd_stb, serial_prog_mode, slave_port_drive;
   reg  [7:0] addr, wdata, three_ovr_en, three_ovr_dir, three_ovr_dat;
   reg  [7:0] two_ext, two_on, v, evn, c_ext, d_ext;
   wire [7:0] rdata, two_pin_in, two_pin_out, two_pin_oe_n, two_pullup_on;
   wire [7:0] three_pin_in, three_pin_out, three_pin_oe_n, three_periph_in;
   wire [7:0] four_pin_in, four_pin_out, four_pin_oe_n, slave_port_pins;
   wire       slave_port_mode, serial_prog_clk, serial_prog_dat, ext_irq_pin;
   wire       ext_irq_edge_sel, ext_irq_event, change_irq_flag;
   integer    fails, checked;
   gpp_ports i_gpp_ports (.mclk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
      .rdata, .two_pin_in, .two_pin_out, .two_pin_oe_n, .two_pullup_on,
      .three_pin_in, .three_pin_out, .three_pin_oe_n, .three_ovr_en,
      .three_ovr_dir, .three_ovr_dat, .three_periph_in, .four_pin_in,
      .four_pin_out, .four_pin_oe_n, .slave_port_data(8'h00),
      .slave_port_drive, .slave_port_pins, .slave_port_mode,
      .serial_prog_mode, .serial_prog_clk, .serial_prog_dat, .ext_irq_pin,
      .ext_irq_edge_sel, .ext_irq_event, .change_irq_flag);
   gpp_pin_env i_gpp_pin_env (.drv(two_pin_out), .oe_n(two_pin_oe_n),
      .pull(two_pullup_on), .ext(two_ext), .ext_on(two_on),
      .pin_fb(two_pin_out), .pin(two_pin_in));
   gpp_pin_env i_gpp_pin_env_c (.drv(three_pin_out), .oe_n(three_pin_oe_n),
      .pull(8'h00), .ext(c_ext), .ext_on(8'hff), .pin_fb(three_pin_out),
      .pin(three_pin_in));
   gpp_pin_env i_gpp_pin_env_d (.drv(four_pin_out), .oe_n(four_pin_oe_n),
      .pull(8'h00), .ext(d_ext), .ext_on(8'hff), .pin_fb(four_pin_out),
      .pin(four_pin_in));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      if (ext_irq_event === 1'b1)
         evn = evn + 8'h01;
   end
   task chk(input [7:0] s, input [7:0] e);
      checked = checked + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      #1;
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task t_reset;
      rdc(8'h81, 8'hff);
      rdc(8'h86, 8'hff);
      rdc(8'h87, 8'hff);
      chk(three_pin_oe_n, 8'hff);
      chk(two_pullup_on, 8'h00);
   endtask
   task t_two;
      wr(8'h81, 8'h7f);
      wr(8'h86, 8'h0f);
      wr(8'h06, 8'ha5);
      @(posedge mclk) two_on <= 8'h00;
      cyc(3);
      chk(two_pullup_on, 8'h0f);
      chk(two_pin_oe_n, 8'h0f);
      chk({7'h00, ext_irq_edge_sel}, 8'h01);
      rdc(8'h06, 8'haf);
   endtask
   task t_change;
      @(posedge mclk) serial_prog_mode <= 1'b1;
      @(posedge mclk) two_on <= 8'hff;
      wr(8'h86, 8'hff);
      cyc(4);
      rdc(8'h06, 8'h00);
      wr(8'h0b, 8'h00);
      cyc(3);
      chk({7'h00, change_irq_flag}, 8'h00);
      v = evn;
      @(posedge mclk) two_ext <= 8'h01;
      cyc(5);
      chk({7'h00, change_irq_flag}, 8'h00);
      chk(evn - v, 8'h01);
      @(posedge mclk) two_ext <= 8'h21;
      cyc(5);
      chk({7'h00, change_irq_flag}, 8'h01);
      wr(8'h0b, 8'h00);
      cyc(2);
      chk({7'h00, change_irq_flag}, 8'h01);
      rdc(8'h06, 8'h21);
      wr(8'h0b, 8'h00);
      cyc(2);
      chk({7'h00, change_irq_flag}, 8'h00);
   endtask
   task t_ovr;
      wr(8'h07, 8'h00);
      wr(8'h87, 8'h00);
      @(posedge mclk) three_ovr_dir <= 8'h01;
      @(posedge mclk) three_ovr_dat <= 8'h02;
      @(posedge mclk) three_ovr_en <= 8'h03;
      cyc(1);
      chk(three_pin_oe_n, 8'h01);
      chk(three_pin_out & 8'h02, 8'h02);
      rdc(8'h87, 8'h01);
      cyc(3);
      chk(three_periph_in, 8'h03);
      @(posedge mclk) three_ovr_en <= 8'h00;
      wr(8'h87, 8'hf0);
      chk(three_pin_oe_n, 8'hf0);
   endtask
   task t_slave;
      wr(8'h89, 8'h10);
      chk({7'h00, slave_port_mode}, 8'h01);
      wr(8'h08, 8'h3c);
      @(posedge mclk) slave_port_drive <= 1'b1;
      cyc(1);
      chk(four_pin_oe_n, 8'h00);
      chk(four_pin_out, 8'h3c);
      @(posedge mclk) slave_port_drive <= 1'b0;
      cyc(3);
      chk(four_pin_oe_n, 8'hff);
      chk(slave_port_pins, 8'h96);
      wr(8'h40, 8'hff);
      rdc(8'h40, 8'h00);
      rdc(8'h81, 8'h7f);
   endtask
   task t_keep;
      wr(8'h06, 8'h5a);
      @(posedge mclk) rst_b <= 1'b0;
      @(posedge mclk) rst_b <= 1'b1;
      cyc(1);
      chk(two_pin_out, 8'h5a);
      rdc(8'h86, 8'hff);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {mclk, rst_b, wr_stb, rd_stb, serial_prog_mode, slave_port_drive} = 6'h0;
      {addr, wdata, three_ovr_en, three_ovr_dir, three_ovr_dat} = 40'h0;
      {two_ext, two_on, v, evn} = 32'h00ff0000;
      {c_ext, d_ext} = 16'hc396;
      fails = 0;
      checked = 0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset;
      t_two;
      t_change;
      t_ovr;
      t_slave;
      t_keep;
      end_sim;
   end
   initial begin
      #40000;
      fails = fails + 1;
      end_sim;
   end
endmodule
